// >>> rtl/fpacu_defs.svh
// Offsets, field positions, reset values and encodings of the floating-point execute slice.
`ifndef FPACU_DEFS_SVH
`define FPACU_DEFS_SVH
// ====================
// Register offsets.
`define FPACU_OFS_SREG 8'h00
`define FPACU_OFS_FPSC 8'h80
`define FPACU_OFS_IRQST 8'h84
`define FPACU_OFS_IRQMSK 8'h88
`define FPACU_OFS_INFO 8'h8c
// ====================
// Status and control field positions.
`define FPACU_B_NZCV 31:28
`define FPACU_B_DN 25
`define FPACU_B_FZ 24
`define FPACU_B_RM 23:22
`define FPACU_B_IOC 0
`define FPACU_B_OFC 2
`define FPACU_B_UFC 3
`define FPACU_B_IXC 4
`define FPACU_B_IDC 7
`define FPACU_FPSC_RST 32'h0000_0000
`define FPACU_FPSC_WMASK 32'hf3c0_009d
// ====================
// Condition flag outcomes and exponent limits in the wide scale.
`define FPACU_NZCV_UN 4'h3
`define FPACU_NZCV_EQ 4'h6
`define FPACU_NZCV_LT 4'h8
`define FPACU_NZCV_GT 4'h2
`define FPACU_SP_EOFS 12'h380
`define FPACU_SP_EMIN 12'h381
`define FPACU_SP_EMAX 12'h47f
`define FPACU_DP_EMIN 12'h001
`define FPACU_DP_EMAX 12'h7ff
`endif

// >>> rtl/fpacu_pkg.sv
// Types shared by the floating-point execute slice.
package fpacu_pkg;
    typedef enum logic [1:0] {FK_USAGE, FK_BUS, FK_MEM, FK_SECURE} fpacu_fault_t;
    typedef enum logic [1:0] {RM_RN, RM_RP, RM_RM, RM_RZ} fpacu_rm_t;
    typedef struct packed {
        logic s;
        logic [11:0] e;
        logic [52:0] m;
        logic nan;
        logic snan;
        logic inf;
        logic zero;
        logic den;
    } fpacu_unp_t;
endpackage : fpacu_pkg

// >>> rtl/fpacu_top.sv
// Floating-point absolute value, add and compare execute slice with its register file.
// Operation
// - Absolute value writes source magnitude, no exceptions.
// - Precision select one means double precision.
// - Double precision undefined when only single supported.
// - Destination extension bit on top for double.
// - Source numbers formed the same way.
// - Add honours rounding and mode controls.
// - Add raises invalid, inexact, overflow, underflow, denormal.
// - Compare writes only the condition flags.
// - Quiet compare invalid only on signalling NaN.
// - Signalling compare invalid on any NaN.
// - Exception bit enables quiet NaN invalid.
// - Compare with zero uses positive zero.
// - Compare raises only invalid and input denormal.
// - Condition and access check precede register use.
// - Bus, usage, memory and security faults reported.
`timescale 1ns/1ns
`include "fpacu_defs.svh"
module fpacu_top #(
    parameter bit DP_SUPPORT = 1'b1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic cond_pass,
    input wire logic fp_access_ok,
    input wire fpacu_pkg::fpacu_fault_t access_fault_kind,
    output logic instr_done,
    output logic instr_unclaimed,
    output logic instr_fault,
    output fpacu_pkg::fpacu_fault_t fault_kind,
    output logic [31:0] fp_status_control,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    // ====================
    // Storage and state.
    logic [31:0] sreg_r [32];
    logic [31:0] fpsc_r;
    logic [31:0] fpsc_nxt;
    logic [2:0] irq_st_r;
    logic [2:0] irq_st_nxt;
    logic [2:0] irq_msk_r;
    logic [15:0] op_cnt_r;
    logic done_r;
    logic uncl_r;
    logic fault_r;
    fpacu_pkg::fpacu_fault_t fkind_r;
    logic [31:0] rdata_r;

    // ====================
    // Helper functions.
    function automatic logic [63:0] fpacu_rd(input logic dp, input logic [4:0] idx);
        return dp ? {sreg_r[{idx[3:0], 1'b1}], sreg_r[{idx[3:0], 1'b0}]} : {32'h0, sreg_r[idx]};
    endfunction : fpacu_rd

    function automatic logic [63:0] fpacu_pack(input logic dp, input logic s, input logic [11:0] e,
                                               input logic [51:0] m);
        return dp ? {s, e[10:0], m} : {32'h0, s, e[7:0], m[22:0]};
    endfunction : fpacu_pack

    function automatic fpacu_pkg::fpacu_unp_t fpacu_unpack(input logic dp, input logic [63:0] x,
                                                           input logic fz);
        fpacu_pkg::fpacu_unp_t u;
        logic ones;
        logic nil;
        logic [51:0] f;
        u = '0;
        ones = dp ? (&x[62:52]) : (&x[30:23]);
        nil = dp ? (x[62:52] == 11'h000) : (x[30:23] == 8'h00);
        f = dp ? x[51:0] : {x[22:0], 29'h0};
        u.s = dp ? x[63] : x[31];
        u.nan = ones & (f != 52'h0);
        u.snan = u.nan & ~f[51];
        u.inf = ones & (f == 52'h0);
        u.den = nil & (f != 52'h0);
        u.zero = nil & (~u.den | fz);
        if (!u.zero) begin
            u.m = {~nil, f};
            if (nil) begin
                u.e = dp ? `FPACU_DP_EMIN : `FPACU_SP_EMIN;
            end else begin
                u.e = dp ? {1'b0, x[62:52]} : {4'h0, x[30:23]} + `FPACU_SP_EOFS;
            end
        end
        return u;
    endfunction : fpacu_unpack

    // ====================
    // Decode.
    logic [15:0] hw1;
    logic [15:0] hw2;
    logic dp;
    logic e_bit;
    logic base_ok;
    logic is_add;
    logic is_abs;
    logic is_cmp;
    logic is_cmpz;
    logic claimed;
    logic undef;
    logic go;
    logic [4:0] d_idx;
    logic [4:0] n_idx;
    logic [4:0] m_idx;
    logic fz;
    logic dnan;
    fpacu_pkg::fpacu_rm_t rm;

    assign hw1 = instr_word[31:16];
    assign hw2 = instr_word[15:0];
    assign dp = hw2[8];
    assign e_bit = hw2[7];
    assign fz = fpsc_r[`FPACU_B_FZ];
    assign dnan = fpsc_r[`FPACU_B_DN];
    assign rm = fpacu_pkg::fpacu_rm_t'(fpsc_r[`FPACU_B_RM]);
    assign base_ok = (hw1[15:8] == 8'hee) && (hw1[5:4] == 2'h3) && (hw2[11:9] == 3'h5) && !hw2[4];
    assign is_add = base_ok && !hw1[7] && !hw2[6];
    assign is_abs = base_ok && hw1[7] && (hw1[3:0] == 4'h0) && (hw2[7:6] == 2'h3);
    assign is_cmp = base_ok && hw1[7] && (hw1[3:0] == 4'h4) && hw2[6];
    assign is_cmpz = base_ok && hw1[7] && (hw1[3:0] == 4'h5) && hw2[6];
    assign claimed = is_add || is_abs || is_cmp || is_cmpz;
    assign d_idx = dp ? {hw1[6], hw2[15:12]} : {hw2[15:12], hw1[6]};
    assign n_idx = dp ? {hw2[7], hw1[3:0]} : {hw1[3:0], hw2[7]};
    assign m_idx = dp ? {hw2[5], hw2[3:0]} : {hw2[3:0], hw2[5]};
    // Double registers beyond the sixteenth do not exist and decode as undefined.
    assign undef = dp && (!DP_SUPPORT || d_idx[4] || m_idx[4] || (is_add && n_idx[4]));
    assign go = instr_valid && claimed && cond_pass && !undef && fp_access_ok;

    // ====================
    // Execute.
    logic [63:0] op_a;
    logic [63:0] op_b;
    fpacu_pkg::fpacu_unp_t ua;
    fpacu_pkg::fpacu_unp_t ub;
    fpacu_pkg::fpacu_unp_t big;
    fpacu_pkg::fpacu_unp_t sml;
    logic sw;
    logic sub;
    logic s;
    logic rb;
    logic st;
    logic inc;
    logic hid;
    logic unord;
    logic eq;
    logic lt;
    logic mag_lt;
    logic [11:0] diff;
    logic [11:0] lz;
    logic [11:0] sh;
    logic [11:0] ex;
    logic [11:0] emin;
    logic [11:0] efld;
    logic [55:0] mb;
    logic [55:0] mbs;
    logic [56:0] sm;
    logic [55:0] nm;
    logic [53:0] mr;
    logic [51:0] qbit;
    logic ex_we;
    logic nzcv_we;
    logic [63:0] ex_res;
    logic [3:0] nzcv;
    logic [7:0] exc;

    always_comb begin
        op_a = fpacu_rd(dp, is_add ? n_idx : d_idx);
        op_b = is_cmpz ? 64'h0 : fpacu_rd(dp, m_idx);
        ua = fpacu_unpack(dp, op_a, fz);
        ub = fpacu_unpack(dp, op_b, fz);
        qbit = dp ? 52'h8_0000_0000_0000 : 52'h0_0000_0040_0000;
        ex_we = 1'b0;
        nzcv_we = 1'b0;
        ex_res = 64'h0;
        nzcv = `FPACU_NZCV_UN;
        exc = 8'h00;
        // Alignment, add and normalisation on a common wide scale.
        sw = {ub.e, ub.m} > {ua.e, ua.m};
        big = sw ? ub : ua;
        sml = sw ? ua : ub;
        sub = ua.s ^ ub.s;
        s = big.s;
        diff = big.e - sml.e;
        mb = {sml.m, 3'h0};
        if (diff > 12'h037) begin
            mbs = {55'h0, |mb};
        end else begin
            mbs = (mb >> diff) | {55'h0, |(mb & ((56'h1 << diff) - 56'h1))};
        end
        sm = sub ? {1'b0, big.m, 3'h0} - {1'b0, mbs} : {1'b0, big.m, 3'h0} + {1'b0, mbs};
        lz = 12'h038;
        for (int i = 0; i < 56; i++) begin
            if (sm[i]) begin
                lz = 12'(55 - i);
            end
        end
        emin = dp ? `FPACU_DP_EMIN : `FPACU_SP_EMIN;
        sh = 12'h0;
        if (sm[56]) begin
            nm = sm[56:1] | {55'h0, sm[0]};
            ex = big.e + 12'h001;
        end else begin
            sh = (lz > big.e - emin) ? big.e - emin : lz;
            nm = sm[55:0] << sh;
            ex = big.e - sh;
        end
        if (dp) begin
            mr = {1'b0, nm[55:3]};
            rb = nm[2];
            st = |nm[1:0];
        end else begin
            mr = {30'h0, nm[55:32]};
            rb = nm[31];
            st = |nm[30:0];
        end
        case (rm)
            fpacu_pkg::RM_RN: inc = rb & (st | mr[0]);
            fpacu_pkg::RM_RP: inc = ~s & (rb | st);
            fpacu_pkg::RM_RM: inc = s & (rb | st);
            default: inc = 1'b0;
        endcase
        mr = mr + {53'h0, inc};
        if (dp ? mr[53] : mr[24]) begin
            mr = mr >> 1;
            ex = ex + 12'h001;
        end
        hid = dp ? mr[52] : mr[23];
        efld = hid ? (dp ? ex : ex - `FPACU_SP_EOFS) : 12'h0;
        // Compare on the same unpacked operands.
        unord = ua.nan | ub.nan;
        eq = (ua.zero & ub.zero) | ({ua.s, ua.e, ua.m} == {ub.s, ub.e, ub.m});
        mag_lt = {ua.e, ua.m} < {ub.e, ub.m};
        lt = sub ? ua.s : (ua.s ? (~mag_lt & ~eq) : mag_lt);
        if (go && is_abs) begin
            ex_we = 1'b1;
            ex_res = dp ? {1'b0, op_b[62:0]} : {32'h0, 1'b0, op_b[30:0]};
        end else if (go && is_add) begin
            ex_we = 1'b1;
            exc[`FPACU_B_IDC] = fz & (ua.den | ub.den);
            if (unord) begin
                exc[`FPACU_B_IOC] = ua.snan | ub.snan;
                if (dnan) begin
                    ex_res = fpacu_pack(dp, 1'b0, 12'hfff, qbit);
                end else if (ua.snan || (ua.nan && !ub.snan)) begin
                    ex_res = op_a | fpacu_pack(dp, 1'b0, 12'h0, qbit);
                end else begin
                    ex_res = op_b | fpacu_pack(dp, 1'b0, 12'h0, qbit);
                end
            end else if (ua.inf && ub.inf && sub) begin
                exc[`FPACU_B_IOC] = 1'b1;
                ex_res = fpacu_pack(dp, 1'b0, 12'hfff, qbit);
            end else if (ua.inf || ub.inf) begin
                ex_res = fpacu_pack(dp, ua.inf ? ua.s : ub.s, 12'hfff, 52'h0);
            end else if (sm == 57'h0) begin
                ex_res = fpacu_pack(dp, sub ? (rm == fpacu_pkg::RM_RM) : s, 12'h0, 52'h0);
            end else if (hid && (ex >= (dp ? `FPACU_DP_EMAX : `FPACU_SP_EMAX))) begin
                exc[`FPACU_B_OFC] = 1'b1;
                exc[`FPACU_B_IXC] = 1'b1;
                if (rm == fpacu_pkg::RM_RN || (rm != fpacu_pkg::RM_RZ && (rm == fpacu_pkg::RM_RM) == s)) begin
                    ex_res = fpacu_pack(dp, s, 12'hfff, 52'h0);
                end else begin
                    ex_res = fpacu_pack(dp, s, 12'hffe, {52{1'b1}});
                end
            end else if (!hid && fz) begin
                exc[`FPACU_B_UFC] = 1'b1;
                ex_res = fpacu_pack(dp, s, 12'h0, 52'h0);
            end else begin
                exc[`FPACU_B_IXC] = rb | st;
                exc[`FPACU_B_UFC] = ~hid & (rb | st);
                ex_res = fpacu_pack(dp, s, efld, mr[51:0]);
            end
        end else if (go && (is_cmp || is_cmpz)) begin
            nzcv_we = 1'b1;
            exc[`FPACU_B_IDC] = fz & (ua.den | ub.den);
            exc[`FPACU_B_IOC] = ua.snan | ub.snan | (unord & e_bit);
            if (unord) begin
                nzcv = `FPACU_NZCV_UN;
            end else if (eq) begin
                nzcv = `FPACU_NZCV_EQ;
            end else if (lt) begin
                nzcv = `FPACU_NZCV_LT;
            end else begin
                nzcv = `FPACU_NZCV_GT;
            end
        end
    end

    // ====================
    // Register file, written by software or by a completing operation.
    logic sreg_hit;
    assign sreg_hit = reg_addr < `FPACU_OFS_FPSC;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < 32; i++) begin
                sreg_r[i] <= 32'h0;
            end
        end else begin
            if (reg_wr && sreg_hit) begin
                sreg_r[reg_addr[6:2]] <= reg_wdata;
            end
            if (ex_we && dp) begin
                sreg_r[{d_idx[3:0], 1'b0}] <= ex_res[31:0];
                sreg_r[{d_idx[3:0], 1'b1}] <= ex_res[63:32];
            end else if (ex_we) begin
                sreg_r[d_idx] <= ex_res[31:0];
            end
        end
    end

    // ====================
    // Status and control: software write first, then sticky flags and outcome.
    always_comb begin
        fpsc_nxt = fpsc_r;
        if (reg_wr && reg_addr == `FPACU_OFS_FPSC) begin
            fpsc_nxt = reg_wdata & `FPACU_FPSC_WMASK;
        end
        fpsc_nxt[7:0] = fpsc_nxt[7:0] | exc;
        if (nzcv_we) begin
            fpsc_nxt[`FPACU_B_NZCV] = nzcv;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fpsc_r <= `FPACU_FPSC_RST;
        end else begin
            fpsc_r <= fpsc_nxt;
        end
    end

    // ====================
    // Completion and fault report.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done_r <= 1'b0;
            uncl_r <= 1'b0;
            fault_r <= 1'b0;
            fkind_r <= fpacu_pkg::FK_USAGE;
        end else begin
            done_r <= instr_valid && claimed;
            uncl_r <= instr_valid && !claimed;
            fault_r <= instr_valid && claimed && cond_pass && (undef || !fp_access_ok);
            fkind_r <= undef ? fpacu_pkg::FK_USAGE : access_fault_kind;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            op_cnt_r <= 16'h0;
        end else if (go) begin
            op_cnt_r <= op_cnt_r + 16'h1;
        end
    end

    // ====================
    // Interrupt status, mask and output.
    logic [2:0] ev;
    assign ev = {instr_valid && claimed && cond_pass && (undef || !fp_access_ok), exc != 8'h00, go};
    always_comb begin
        irq_st_nxt = irq_st_r;
        if (reg_wr && reg_addr == `FPACU_OFS_IRQST) begin
            irq_st_nxt = irq_st_r & ~reg_wdata[2:0];
        end
        irq_st_nxt = irq_st_nxt | ev;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_st_r <= 3'h0;
            irq_msk_r <= 3'h0;
        end else begin
            irq_st_r <= irq_st_nxt;
            if (reg_wr && reg_addr == `FPACU_OFS_IRQMSK) begin
                irq_msk_r <= reg_wdata[2:0];
            end
        end
    end

    // ====================
    // Register read port.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_r <= 32'h0;
        end else if (reg_rd) begin
            if (sreg_hit) begin
                rdata_r <= sreg_r[reg_addr[6:2]];
            end else begin
                case (reg_addr)
                    `FPACU_OFS_FPSC: rdata_r <= fpsc_r;
                    `FPACU_OFS_IRQST: rdata_r <= {29'h0, irq_st_r};
                    `FPACU_OFS_IRQMSK: rdata_r <= {29'h0, irq_msk_r};
                    `FPACU_OFS_INFO: rdata_r <= {op_cnt_r, 15'h0, DP_SUPPORT};
                    default: rdata_r <= 32'h0;
                endcase
            end
        end else begin
            rdata_r <= 32'h0;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = |(irq_st_r & irq_msk_r);
    assign instr_done = done_r;
    assign instr_unclaimed = uncl_r;
    assign instr_fault = fault_r;
    assign fault_kind = fkind_r;
    assign fp_status_control = fpsc_r;
endmodule : fpacu_top

// >>> verification/fpacu_checker.sv
// Concurrent checks on the ports of the floating-point execute slice.
`timescale 1ns/1ns
module fpacu_checker #(
    parameter bit DP_SUPPORT = 1'b1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic cond_pass,
    input wire logic fp_access_ok,
    input wire fpacu_pkg::fpacu_fault_t access_fault_kind,
    input wire logic instr_done,
    input wire logic instr_unclaimed,
    input wire logic instr_fault,
    input wire fpacu_pkg::fpacu_fault_t fault_kind,
    input wire logic [31:0] fp_status_control,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    // ====================
    // Decode of the absolute and compare forms.
    logic fam;
    logic is_abs;
    logic is_cmp;
    assign fam = instr_valid && !reg_wr && instr_word[31:24] == 8'hee && instr_word[21:20] == 2'b11
        && instr_word[11:9] == 3'b101 && !instr_word[4];
    assign is_abs = fam && instr_word[23] && instr_word[19:16] == 4'h0 && instr_word[7:6] == 2'b11;
    assign is_cmp = fam && instr_word[23] && instr_word[19:17] == 3'b010 && instr_word[6];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ====================
    // Assertions.
    a_answer_once: assert property (instr_valid |=> instr_done != instr_unclaimed)
        else $error("answer not unique");
    a_no_stray_done: assert property (!instr_valid |=> !instr_done && !instr_unclaimed)
        else $error("answer without an instruction");
    a_fault_with_done: assert property (instr_fault |-> instr_done)
        else $error("fault without done");
    a_cond_skip: assert property (instr_valid && !cond_pass && !reg_wr
        |=> !instr_fault && $stable(fp_status_control))
        else $error("skipped op acted");
    a_access_fault: assert property (instr_valid && cond_pass && !fp_access_ok |=> instr_unclaimed || instr_fault
        && (fault_kind == $past(access_fault_kind) || fault_kind == fpacu_pkg::FK_USAGE))
        else $error("access fault lost");
    a_dp_undef: assert property (!DP_SUPPORT && instr_valid && cond_pass && instr_word[8]
        |=> instr_unclaimed || instr_fault && fault_kind == fpacu_pkg::FK_USAGE)
        else $error("double not refused");
    a_fault_keeps: assert property (instr_fault && !$past(reg_wr) |-> $stable(fp_status_control))
        else $error("fault changed status");
    a_abs_quiet: assert property (is_abs |=> $stable(fp_status_control))
        else $error("absolute value changed status");
    a_cmp_flags: assert property (is_cmp |=> $stable(fp_status_control[27:8]) && $stable(fp_status_control[6:1]))
        else $error("compare touched status");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule : fpacu_checker
bind fpacu_top fpacu_checker #(.DP_SUPPORT(DP_SUPPORT)) fpacu_checker_i (
    .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word), .cond_pass(cond_pass),
    .fp_access_ok(fp_access_ok), .access_fault_kind(access_fault_kind), .instr_done(instr_done),
    .instr_unclaimed(instr_unclaimed), .instr_fault(instr_fault), .fault_kind(fault_kind),
    .fp_status_control(fp_status_control), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// >>> verification/fpacu_issuer.sv
// Model of the instruction issue side that offers encoded instructions.
`timescale 1ns/1ns
module fpacu_issuer (
    input wire logic clk,
    input wire logic start,
    input wire logic [19:0] req,
    input wire logic cond,
    input wire logic acc_ok,
    input wire fpacu_pkg::fpacu_fault_t acc_kind,
    output logic instr_valid,
    output logic [31:0] instr_word,
    output logic cond_pass,
    output logic fp_access_ok,
    output fpacu_pkg::fpacu_fault_t access_fault_kind
);
    // ====================
    // Encoder: request is kind, precision, exception bit, then three register numbers.
    function automatic logic [4:0] fld(input logic p, input logic [4:0] r);
        return p ? {r[3:0], r[4]} : r;
    endfunction : fld
    function automatic logic [31:0] enc(input logic [19:0] q);
        logic [4:0] fd;
        logic [4:0] fn;
        logic [4:0] fm;
        logic [3:0] op1;
        logic b7;
        fd = fld(q[16], q[14:10]);
        fn = fld(q[16], q[9:5]);
        fm = fld(q[16], q[4:0]);
        op1 = q[19:17] == 3'd0 ? fn[4:1] : (q[19:17] == 3'd1 ? 4'h0 : {3'b010, q[17]});
        b7 = q[19:17] == 3'd0 ? fn[0] : (q[19:17] == 3'd1 ? 1'b1 : q[15]);
        if (q[19:17] > 3'd3) begin
            return 32'h0;
        end
        return {8'hee, q[19:17] != 3'd0, fd[0], 2'b11, op1, fd[4:1], 3'b101, q[16], b7, q[19:17] != 3'd0,
            fm[0], 1'b0, fm[4:1]};
    endfunction : enc
    initial begin
        instr_valid = 1'b0;
        instr_word = 32'h0;
        cond_pass = 1'b1;
        fp_access_ok = 1'b1;
        access_fault_kind = fpacu_pkg::FK_USAGE;
    end
    // Outside an offer the word toggles so a stale value is never mistaken for a live one.
    always @(posedge clk) begin
        instr_valid <= start;
        instr_word <= start ? enc(req) : ~instr_word;
        cond_pass <= cond;
        fp_access_ok <= acc_ok;
        access_fault_kind <= acc_kind;
    end
endmodule : fpacu_issuer

// >>> verification/fpacu_tb_top.sv
// Self-checking testbench of the floating-point execute slice.
`timescale 1ns/1ns
module fpacu_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, instr_word, fpsc;
    logic instr_valid, cond_pass, fp_access_ok, instr_done, instr_unclaimed, instr_fault, irq;
    fpacu_pkg::fpacu_fault_t access_fault_kind, fault_kind, kind_s;
    logic start = 1'b0;
    logic [19:0] req = 20'h0;
    logic cnd = 1'b1;
    logic acc = 1'b1;
    fpacu_pkg::fpacu_fault_t akind = fpacu_pkg::FK_USAGE;
    logic done_s, unc_s, flt_s, p;
    logic [63:0] v, x;
    int n_errors = 0;
    int n_checks = 0;
    integer seed = 32'hc254bf96;
    int a, b, i, r, n, m, d;
    logic [38:0] ct [9] = '{{32'h3f800000, 7'b0010000}, {32'h40000000, 7'b0001100}, {32'h40400000, 7'b0000100},
        {32'h7fc00000, 7'b0000110}, {32'h7fc00000, 7'b1000111}, {32'h7f800001, 7'b0000111},
        {32'h80000000, 7'b0101100}, {32'hbf800000, 7'b0110000}, {32'h3f800000, 7'b0100100}};
    always #25 clk = ~clk;
    fpacu_top #(.DP_SUPPORT(1'b1)) fpacu_top_i (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .cond_pass(cond_pass), .fp_access_ok(fp_access_ok),
        .access_fault_kind(access_fault_kind), .instr_done(instr_done), .instr_unclaimed(instr_unclaimed),
        .instr_fault(instr_fault), .fault_kind(fault_kind), .fp_status_control(fpsc), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    fpacu_issuer fpacu_issuer_i (.clk(clk), .start(start), .req(req), .cond(cnd), .acc_ok(acc), .acc_kind(akind),
        .instr_valid(instr_valid), .instr_word(instr_word), .cond_pass(cond_pass), .fp_access_ok(fp_access_ok),
        .access_fault_kind(access_fault_kind));
    // ====================
    // Helpers.
    function automatic logic [63:0] f64(input int k);
        return $realtobits(real'(k));
    endfunction : f64
    function automatic logic [31:0] f32(input int k);
        logic [63:0] w;
        logic [10:0] e;
        w = f64(k);
        e = w[62:52] - 11'd896;
        return k == 0 ? 32'h0 : {w[63], e[7:0], w[51:29]};
    endfunction : f32
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %h != %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= dat;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [31:0] dat);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        dat = reg_rdata;
    endtask : rd
    task automatic ld(input logic dp, input int rg, input logic [63:0] val);
        if (dp) begin
            wr(8'(rg * 8), val[31:0]);
            wr(8'(rg * 8 + 4), val[63:32]);
        end else begin
            wr(8'(rg * 4), val[31:0]);
        end
    endtask : ld
    task automatic get(input logic dp, input int rg, output logic [63:0] val);
        val = 64'h0;
        if (dp) begin
            rd(8'(rg * 8), val[31:0]);
            rd(8'(rg * 8 + 4), val[63:32]);
        end else begin
            rd(8'(rg * 4), val[31:0]);
        end
    endtask : get
    task automatic op(input logic [2:0] k, input logic dp, input logic e, input int rd_i, input int rn, input int rm);
        @(posedge clk);
        start <= 1'b1;
        req <= {k, dp, e, 5'(rd_i), 5'(rn), 5'(rm)};
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        #1;
        done_s = instr_done;
        unc_s = instr_unclaimed;
        flt_s = instr_fault;
        kind_s = fault_kind;
    endtask : op
    task automatic end_sim;
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
    // ====================
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        wr(8'h90, 32'hffffffff);
        for (i = 0; i < 5; i++) begin
            rd(8'h80 + 8'(4 * i), v[31:0]);
            chk(v[31:0], i == 3 ? 32'h1 : 32'h0);
        end
        op(3'd0, 1'b0, 1'b0, 2, 0, 1);
        chk(irq, 1'b0);
        wr(8'h84, 32'h7);
        wr(8'h88, 32'h1);
        for (i = 0; i < 24; i++) begin
            p = i[0];
            r = p ? 5 : 10;
            n = {$random(seed)} % r;
            m = n + r;
            d = m + r;
            a = $random(seed) % 1000;
            b = $random(seed) % 1000;
            ld(p, n, p ? f64(a) : {32'h0, f32(a)});
            ld(p, m, p ? f64(b) : {32'h0, f32(b)});
            op(3'd0, p, 1'b0, d, n, m);
            get(p, d, v);
            chk(v, p ? f64(a + b) : {32'h0, f32(a + b)});
            x = {$random(seed), $random(seed)};
            ld(p, n, x);
            op(3'd1, p, 1'b0, d, 0, n);
            get(p, d, v);
            chk(v, p ? {1'b0, x[62:0]} : {33'h0, x[30:0]});
        end
        chk(fpsc, 32'h0);
        chk(irq, 1'b1);
        wr(8'h84, 32'h7);
        chk(irq, 1'b0);
        ld(1'b0, 0, 64'h7f7fffff);
        ld(1'b0, 1, 64'h7f7fffff);
        op(3'd0, 1'b0, 1'b0, 2, 0, 1);
        get(1'b0, 2, v);
        chk(v, 64'h7f800000);
        chk(fpsc & 32'h9d, 32'h14);
        wr(8'h80, 32'h00c00000);
        op(3'd0, 1'b0, 1'b0, 3, 0, 1);
        get(1'b0, 3, v);
        chk(v, 64'h7f7fffff);
        ld(1'b0, 1, 64'h40000000);
        for (i = 0; i < 9; i++) begin
            wr(8'h80, 32'h0);
            ld(1'b0, 0, {32'h0, ct[i][38:7]});
            op(ct[i][5] ? 3'd3 : 3'd2, 1'b0, ct[i][6], 0, 0, 1);
            chk({fpsc[31:28], fpsc[0]}, ct[i][4:0]);
            get(1'b0, 0, v);
            chk(v[31:0], ct[i][38:7]);
        end
        ld(1'b1, 0, f64(1));
        ld(1'b1, 1, f64(2));
        op(3'd2, 1'b1, 1'b0, 0, 0, 1);
        chk(fpsc[31:28], 4'h8);
        ld(1'b0, 5, 64'h12345678);
        cnd <= 1'b0;
        op(3'd1, 1'b0, 1'b0, 5, 0, 1);
        chk({done_s, flt_s}, 2'b10);
        cnd <= 1'b1;
        acc <= 1'b0;
        for (i = 0; i < 4; i++) begin
            akind <= fpacu_pkg::fpacu_fault_t'(i[1:0]);
            op(3'd1, 1'b0, 1'b0, 5, 0, 1);
            chk({done_s, flt_s, kind_s}, {2'b11, i[1:0]});
        end
        acc <= 1'b1;
        get(1'b0, 5, v);
        chk(v, 64'h12345678);
        op(3'd1, 1'b1, 1'b0, 16, 0, 1);
        chk({flt_s, kind_s}, {1'b1, fpacu_pkg::FK_USAGE});
        op(3'd4, 1'b0, 1'b0, 0, 0, 0);
        chk({done_s, unc_s}, 2'b01);
        end_sim();
    end
endmodule : fpacu_tb_top
